// ### verilog/pldc_cell.sv
// pldc_cell: two logic arrays plus the 8-bit dynamically configured datapath
// assumes bus, configuration and routing signals all come from logic on clk
`timescale 1ns/10ps
`default_nettype none
module pldc_cell
   import pldc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [2:0] bus_addr,
   input wire logic [DW-1:0] bus_wdata,
   output logic [DW-1:0] bus_rdata_ff,
   input wire logic store_wr,
   input wire logic [2:0] store_addr,
   input wire pldc_dyn_cfg_t store_wdata,
   input wire pldc_static_cfg_t static_cfg,
   input wire pldc_la_cfg_t la_cfg0,
   input wire pldc_la_cfg_t la_cfg1,
   input wire logic [LA_INPUTS-1:0] la_in0,
   input wire logic [LA_INPUTS-1:0] la_in1,
   output logic [LA_OUTS-1:0] la_out0,
   output logic [LA_OUTS-1:0] la_out1,
   input wire logic [ROUTE_INS-1:0] route_in,
   output logic [ROUTE_OUTS-1:0] route_out_ff,
   input wire pldc_chain_t chain_in,
   output var pldc_chain_t chain_out
);
   logic [1:0][DW-1:0] acc_ff, nxt_acc, dat_ff, nxt_dat;
   logic [1:0][FIFO_DEPTH-1:0][DW-1:0] mem_ff, nxt_mem;
   logic [1:0][1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [1:0][2:0] cnt_ff, nxt_cnt;
   pldc_dyn_cfg_t store_ff [STORE_WORDS];
   pldc_dyn_cfg_t nxt_store [STORE_WORDS];
   logic [DW-1:0] nxt_rdata;
   logic [ROUTE_OUTS-1:0] nxt_rout;

   pldc_dyn_cfg_t cur;
   logic [2:0] cfg_addr;
   logic [DW-1:0] opa, opb, opa_m, opb_m, lowmask, alu, post, res;
   logic [DW:0] sum;
   logic cin, sin, crc_in, fb, carry_out, sh_out, ovf, bsign, arith;
   logic [1:0] cmp_eq, cmp_lt;
   logic [COND_NUM-1:0] cond;
   logic [1:0] push, pop;
   logic [1:0][DW-1:0] din, head;

   pldc_logic_array u_array0 (
      .clk(clk),
      .reset_n(reset_n),
      .la_in(la_in0),
      .cfg(la_cfg0),
      .la_out(la_out0)
   );
   pldc_logic_array u_array1 (
      .clk(clk),
      .reset_n(reset_n),
      .la_in(la_in1),
      .cfg(la_cfg1),
      .la_out(la_out1)
   );

   function automatic logic [DW-1:0] pick(input pldc_src_t s, input logic [1:0][DW-1:0] a,
                                         input logic [1:0][DW-1:0] d);
      case (s)
         SRC_ACC0: pick = a[0];
         SRC_ACC1: pick = a[1];
         SRC_DAT0: pick = d[0];
         default: pick = d[1];
      endcase
   endfunction : pick

   // sequencer picks the word each cycle; array 0 may drive it directly
   assign cfg_addr = static_cfg.addr_from_la ? la_out0[2:0] : route_in[RIN_ADDR +: 3];
   assign cur = store_ff[cfg_addr];
   assign cin = static_cfg.chain_en ? chain_in.carry : route_in[RIN_CARRY];
   assign sin = static_cfg.chain_en ? chain_in.shift : route_in[RIN_SHIFT];
   assign crc_in = static_cfg.chain_en ? chain_in.shift : route_in[RIN_CRC];
   assign lowmask = ALL_ONES >> (MSB_TOP - static_cfg.msb);

   always_comb begin
      opa = pick(cur.opa, acc_ff, dat_ff);
      opb = pick(cur.opb, acc_ff, dat_ff);
      // bits above the msb are cleared so the carry lands just above it
      opa_m = opa & lowmask;
      opb_m = opb & lowmask;
      arith = 1'b1;
      bsign = 1'b0;
      case (cur.op)
         ALU_INC: sum = {1'b0, opa_m} + 9'h001;
         ALU_DEC: begin
            sum = {1'b0, opa_m} - 9'h001;
            bsign = 1'b1;
         end
         ALU_ADD: begin
            sum = {1'b0, opa_m} + {1'b0, opb_m} + {8'h00, cin};
            bsign = opb_m[static_cfg.msb];
         end
         ALU_SUB: begin
            sum = {1'b0, opa_m} - {1'b0, opb_m} - {8'h00, cin};
            bsign = ~opb_m[static_cfg.msb];
         end
         ALU_AND: begin
            sum = {1'b0, opa & opb};
            arith = 1'b0;
         end
         ALU_OR: begin
            sum = {1'b0, opa | opb};
            arith = 1'b0;
         end
         ALU_XOR: begin
            sum = {1'b0, opa ^ opb};
            arith = 1'b0;
         end
         default: begin
            sum = {1'b0, opa};
            arith = 1'b0;
         end
      endcase
      alu = sum[DW-1:0];
      carry_out = arith & sum[{1'b0, static_cfg.msb} + 4'h1];
      ovf = arith & (opa_m[static_cfg.msb] == bsign) &
            (alu[static_cfg.msb] != opa_m[static_cfg.msb]);
   end

   always_comb begin
      post = alu;
      sh_out = 1'b0;
      fb = opa[static_cfg.msb] ^ crc_in;
      if (static_cfg.crc_en) begin
         post = {opa[DW-2:0], 1'b0} ^ (fb ? static_cfg.poly : REG_RST);
         sh_out = fb;
      end else begin
         case (cur.post)
            POST_SHL: begin
               post = {alu[DW-2:0], sin};
               sh_out = alu[static_cfg.msb];
            end
            POST_SHR: begin
               post = alu >> 1;
               post[static_cfg.msb] = sin;
               sh_out = alu[0];
            end
            POST_SWAP: post = {alu[NIB-1:0], alu[DW-1:NIB]};
            POST_ORM: post = alu | static_cfg.or_mask;
            default: post = alu;
         endcase
      end
      res = post & static_cfg.out_mask & lowmask;
   end

   always_comb begin
      logic [DW-1:0] x;
      logic [DW-1:0] y;
      logic [DW-1:0] m;
      x = REG_RST;
      y = REG_RST;
      m = REG_RST;
      for (int k = 0; k < 2; k++) begin
         case (static_cfg.cmp_pair[k])
            2'h0: begin
               x = acc_ff[0];
               y = dat_ff[0];
            end
            2'h1: begin
               x = acc_ff[1];
               y = dat_ff[1];
            end
            2'h2: begin
               x = acc_ff[0];
               y = acc_ff[1];
            end
            default: begin
               x = dat_ff[0];
               y = dat_ff[1];
            end
         endcase
         m = static_cfg.cmp_mask[k];
         cmp_eq[k] = ((x ^ y) & m) == REG_RST;
         cmp_lt[k] = (x & m) < (y & m);
      end
      // the lower neighbour decides only when this byte is equal
      if (static_cfg.chain_en) begin
         cmp_lt[0] = cmp_lt[0] | (cmp_eq[0] & chain_in.lt);
         cmp_eq[0] = cmp_eq[0] & chain_in.eq;
      end
   end

   always_comb begin
      cond = '0;
      cond[CND_EQ0] = cmp_eq[0];
      cond[CND_LT0] = cmp_lt[0];
      cond[CND_EQ1] = cmp_eq[1];
      cond[CND_LT1] = cmp_lt[1];
      cond[CND_ZERO0] = acc_ff[0] == REG_RST;
      cond[CND_ZERO1] = acc_ff[1] == REG_RST;
      cond[CND_ONES0] = acc_ff[0] == ALL_ONES;
      cond[CND_ONES1] = acc_ff[1] == ALL_ONES;
      cond[CND_OVF] = ovf;
      cond[CND_CARRY] = carry_out;
      cond[CND_SHOUT] = sh_out;
      cond[CND_FIFO0_EMPTY] = cnt_ff[0] == 3'h0;
      cond[CND_FIFO0_FULL] = cnt_ff[0] == FIFO_FULL_CNT;
      cond[CND_FIFO1_EMPTY] = cnt_ff[1] == 3'h0;
      cond[CND_FIFO1_FULL] = cnt_ff[1] == FIFO_FULL_CNT;
      for (int i = 0; i < ROUTE_OUTS; i++) begin
         nxt_rout[i] = cond[static_cfg.out_sel[i]];
      end
   end

   // neighbours see this cell's result in the same cycle, hence no flop here
   always_comb begin
      chain_out.carry = carry_out;
      chain_out.shift = sh_out;
      chain_out.eq = cmp_eq[0];
      chain_out.lt = cmp_lt[0];
   end

   always_comb begin
      nxt_acc = acc_ff;
      nxt_dat = dat_ff;
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      nxt_store = store_ff;
      if (store_wr) begin
         nxt_store[store_addr] = store_wdata;
      end
      if (cur.dst[0]) begin
         nxt_acc[0] = res;
      end
      if (cur.dst[1]) begin
         nxt_acc[1] = res;
      end
      for (int i = 0; i < 2; i++) begin
         head[i] = (cnt_ff[i] == 3'h0) ? REG_RST : mem_ff[i][rp_ff[i]];
         if (static_cfg.fifo_out_dir[i]) begin
            push[i] = cur.fifo_capture;
            din[i] = cur.fifo_from_alu ? res : acc_ff[i];
            pop[i] = bus_rd && bus_addr == OFS_FIFO0 + 3'(i);
         end else begin
            push[i] = bus_wr && bus_addr == OFS_FIFO0 + 3'(i);
            din[i] = bus_wdata;
            pop[i] = cur.acc_load | cur.dat_load;
            if (cnt_ff[i] != 3'h0 && cur.acc_load) begin
               nxt_acc[i] = head[i];
            end
            if (cnt_ff[i] != 3'h0 && cur.dat_load) begin
               nxt_dat[i] = head[i];
            end
         end
         if (push[i] && cnt_ff[i] != FIFO_FULL_CNT) begin
            nxt_mem[i][wp_ff[i]] = din[i];
            nxt_wp[i] = wp_ff[i] + 2'h1;
            nxt_cnt[i] = nxt_cnt[i] + 3'h1;
         end
         if (pop[i] && cnt_ff[i] != 3'h0) begin
            nxt_rp[i] = rp_ff[i] + 2'h1;
            nxt_cnt[i] = nxt_cnt[i] - 3'h1;
         end
      end
      // software writes land after the datapath so they win a collision
      if (bus_wr) begin
         case (bus_addr)
            OFS_ACC0: nxt_acc[0] = bus_wdata;
            OFS_ACC1: nxt_acc[1] = bus_wdata;
            OFS_DAT0: nxt_dat[0] = bus_wdata;
            OFS_DAT1: nxt_dat[1] = bus_wdata;
            default: ;
         endcase
      end
      nxt_rdata = bus_rdata_ff;
      if (bus_rd) begin
         case (bus_addr)
            OFS_ACC0: nxt_rdata = acc_ff[0];
            OFS_ACC1: nxt_rdata = acc_ff[1];
            OFS_DAT0: nxt_rdata = dat_ff[0];
            OFS_DAT1: nxt_rdata = dat_ff[1];
            OFS_FIFO0: nxt_rdata = head[0];
            OFS_FIFO1: nxt_rdata = head[1];
            default: nxt_rdata = REG_RST;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_ff <= '0;
         dat_ff <= '0;
         mem_ff <= '0;
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         bus_rdata_ff <= REG_RST;
         route_out_ff <= '0;
         for (int w = 0; w < STORE_WORDS; w++) begin
            store_ff[w] <= STORE_RST;
         end
      end else begin
         acc_ff <= nxt_acc;
         dat_ff <= nxt_dat;
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         bus_rdata_ff <= nxt_rdata;
         route_out_ff <= nxt_rout;
         store_ff <= nxt_store;
      end
   end

   logic sel_cond0;
   assign sel_cond0 = cond[static_cfg.out_sel[0]];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_fifo_full_hold: assert property (push[0] && !pop[0] && cnt_ff[0] == FIFO_FULL_CNT
      |=> $stable(mem_ff[0]) && $stable(wp_ff[0]) && cnt_ff[0] == FIFO_FULL_CNT)
      else $error("full fifo took a write");
   a_fifo_empty_pop: assert property (pop[1] && !push[1] && cnt_ff[1] == 3'h0
      |=> $stable(rp_ff[1]) && cnt_ff[1] == 3'h0)
      else $error("empty fifo advanced on a read");
   a_fifo_push_count: assert property (push[1] && !pop[1] && cnt_ff[1] < FIFO_FULL_CNT
      |=> cnt_ff[1] == $past(cnt_ff[1]) + 3'h1)
      else $error("fifo count did not rise on a push");
   a_acc_result: assert property (cur.dst[0] && !(cur.acc_load && !static_cfg.fifo_out_dir[0])
      && !(bus_wr && bus_addr == OFS_ACC0) |=> acc_ff[0] == $past(res))
      else $error("accumulator missed the alu result");
   a_alu_add: assert property (cur.op == ALU_ADD && !static_cfg.crc_en && cur.post == POST_NONE
      && static_cfg.msb == MSB_TOP |-> res == ((opa + opb + DW'(cin)) & static_cfg.out_mask))
      else $error("add result wrong");
   a_nibble_swap: assert property (cur.post == POST_SWAP && !static_cfg.crc_en
      && static_cfg.msb == MSB_TOP |-> res == ({alu[NIB-1:0], alu[DW-1:NIB]} & static_cfg.out_mask))
      else $error("nibble swap wrong");
   a_store_write: assert property (store_wr
      |=> store_ff[$past(store_addr)] == $past(store_wdata))
      else $error("configuration word not stored");
   a_bus_readback: assert property (bus_rd && bus_addr == OFS_DAT1
      |=> bus_rdata_ff == $past(dat_ff[1]))
      else $error("data register read back wrong");
   a_route_cond: assert property (1'b1 |=> route_out_ff[0] == $past(sel_cond0))
      else $error("routing output does not follow its condition");

   c_fifo_full: cover property (cnt_ff[0] == FIFO_FULL_CNT ##1 push[0]);
   c_carry_out: cover property (cur.op == ALU_ADD && carry_out);
   c_crc_step: cover property (static_cfg.crc_en && fb ##1 static_cfg.crc_en);
   c_route_hit: cover property (route_out_ff[0] ##1 !route_out_ff[0]);
endmodule : pldc_cell
`default_nettype wire

// ### pkg/pldc_pkg.sv
// pldc_pkg: constants, configuration layouts and types of the logic/datapath cell
// assumes every design file of the cell imports it whole
package pldc_pkg;
   localparam int DW = 8;
   localparam int NIB = 4;
   localparam int LA_INPUTS = 12;
   localparam int LA_TERMS = 8;
   localparam int LA_OUTS = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int STORE_WORDS = 8;
   localparam int COND_NUM = 16;
   localparam int ROUTE_INS = 6;
   localparam int ROUTE_OUTS = 6;
   // routing input bit positions
   localparam int RIN_ADDR = 0;
   localparam int RIN_SHIFT = 3;
   localparam int RIN_CARRY = 4;
   localparam int RIN_CRC = 5;
   // system bus offsets of the working registers
   localparam logic [2:0] OFS_ACC0 = 3'h0;
   localparam logic [2:0] OFS_ACC1 = 3'h1;
   localparam logic [2:0] OFS_DAT0 = 3'h2;
   localparam logic [2:0] OFS_DAT1 = 3'h3;
   localparam logic [2:0] OFS_FIFO0 = 3'h4;
   localparam logic [2:0] OFS_FIFO1 = 3'h5;
   localparam logic [DW-1:0] REG_RST = 8'h00;
   localparam logic [DW-1:0] ALL_ONES = 8'hff;
   localparam logic [2:0] FIFO_FULL_CNT = 3'h4;
   localparam logic [2:0] MSB_TOP = 3'h7;
   // condition vector positions
   localparam logic [3:0] CND_EQ0 = 4'h0;
   localparam logic [3:0] CND_LT0 = 4'h1;
   localparam logic [3:0] CND_EQ1 = 4'h2;
   localparam logic [3:0] CND_LT1 = 4'h3;
   localparam logic [3:0] CND_ZERO0 = 4'h4;
   localparam logic [3:0] CND_ZERO1 = 4'h5;
   localparam logic [3:0] CND_ONES0 = 4'h6;
   localparam logic [3:0] CND_ONES1 = 4'h7;
   localparam logic [3:0] CND_OVF = 4'h8;
   localparam logic [3:0] CND_CARRY = 4'h9;
   localparam logic [3:0] CND_SHOUT = 4'ha;
   localparam logic [3:0] CND_FIFO0_EMPTY = 4'hb;
   localparam logic [3:0] CND_FIFO0_FULL = 4'hc;
   localparam logic [3:0] CND_FIFO1_EMPTY = 4'hd;
   localparam logic [3:0] CND_FIFO1_FULL = 4'he;
   localparam logic [3:0] CND_LOW = 4'hf;

   typedef enum logic [2:0] {
      ALU_PASS = 3'h0, ALU_INC = 3'h1, ALU_DEC = 3'h2, ALU_ADD = 3'h3,
      ALU_SUB = 3'h4, ALU_AND = 3'h5, ALU_OR = 3'h6, ALU_XOR = 3'h7
   } pldc_alu_op_t;
   typedef enum logic [2:0] {
      POST_NONE = 3'h0, POST_SHL = 3'h1, POST_SHR = 3'h2, POST_SWAP = 3'h3, POST_ORM = 3'h4
   } pldc_post_t;
   typedef enum logic [1:0] {
      SRC_ACC0 = 2'h0, SRC_ACC1 = 2'h1, SRC_DAT0 = 2'h2, SRC_DAT1 = 2'h3
   } pldc_src_t;
   // one configuration store word, 16 bits
   typedef struct packed {
      logic fifo_from_alu;
      logic fifo_capture;
      logic dat_load;
      logic acc_load;
      logic [1:0] dst;
      pldc_post_t post;
      pldc_src_t opb;
      pldc_src_t opa;
      pldc_alu_op_t op;
   } pldc_dyn_cfg_t;
   localparam pldc_dyn_cfg_t STORE_RST = 16'h0000;
   typedef struct packed {
      logic [LA_TERMS-1:0][LA_INPUTS-1:0] use_true;
      logic [LA_TERMS-1:0][LA_INPUTS-1:0] use_comp;
      logic [LA_OUTS-1:0][LA_TERMS-1:0] or_sel;
      logic [LA_OUTS-1:0] reg_out;
   } pldc_la_cfg_t;
   typedef struct packed {
      logic [2:0] msb;
      logic [DW-1:0] out_mask;
      logic [DW-1:0] or_mask;
      logic [1:0][DW-1:0] cmp_mask;
      logic [1:0][1:0] cmp_pair;
      logic crc_en;
      logic [DW-1:0] poly;
      logic [1:0] fifo_out_dir;
      logic chain_en;
      logic addr_from_la;
      logic [ROUTE_OUTS-1:0][3:0] out_sel;
   } pldc_static_cfg_t;
   typedef struct packed {
      logic carry;
      logic shift;
      logic eq;
      logic lt;
   } pldc_chain_t;
endpackage : pldc_pkg

// ### verilog/pldc_logic_array.sv
// pldc_logic_array: one sum-of-products logic array of the cell
// assumes static configuration held stable by the surrounding configuration memory
`timescale 1ns/10ps
`default_nettype none
module pldc_logic_array
   import pldc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [LA_INPUTS-1:0] la_in,
   input wire pldc_la_cfg_t cfg,
   output logic [LA_OUTS-1:0] la_out
);
   logic [LA_TERMS-1:0] term;
   logic [LA_OUTS-1:0] sum_comb;
   logic [LA_OUTS-1:0] out_ff;
   logic [LA_OUTS-1:0] nxt_out;

   always_comb begin
      for (int t = 0; t < LA_TERMS; t++) begin
         // a term with no literal chosen stays low rather than reading as true
         term[t] = (|(cfg.use_true[t] | cfg.use_comp[t])) &
                   ~(|(cfg.use_true[t] & ~la_in)) & ~(|(cfg.use_comp[t] & la_in));
      end
      for (int o = 0; o < LA_OUTS; o++) begin
         sum_comb[o] = |(cfg.or_sel[o] & term);
      end
      nxt_out = sum_comb;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_ff <= '0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   always_comb begin
      for (int o = 0; o < LA_OUTS; o++) begin
         la_out[o] = cfg.reg_out[o] ? out_ff[o] : sum_comb[o];
      end
   end
endmodule : pldc_logic_array
`default_nettype wire

// ### tb/pldc_bus_host.sv
// pldc_bus_host: system bus side model for the working register port
// assumes one clock; requests launch on the falling edge and are taken on the rising one
`timescale 1ns/10ps
`default_nettype none
module pldc_bus_host
   import pldc_pkg::*;
(
   input wire logic clk,
   output logic bus_wr,
   output logic bus_rd,
   output logic [2:0] bus_addr,
   output logic [DW-1:0] bus_wdata,
   input wire logic [DW-1:0] bus_rdata_ff
);
   initial begin
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 3'h7;
      bus_wdata = 8'ha5;
   end
   task automatic wr(input logic [2:0] a, input logic [DW-1:0] d);
      @(negedge clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
      // released data must not look like the last value
      bus_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [DW-1:0] d);
      @(negedge clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      d = bus_rdata_ff;
   endtask : rd
endmodule : pldc_bus_host
`default_nettype wire

// ### tb/programmable_logic_datapath_cell_bench.sv
// bench for pldc_cell: alu/post table, logic arrays, fifo limits, conditions, reset
// assumes pldc_bus_host as system bus master; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module programmable_logic_datapath_cell_bench;
   import pldc_pkg::*;
   typedef struct {pldc_alu_op_t op; pldc_post_t post; logic [7:0] exp;} pldc_row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic bus_wr, bus_rd, store_wr;
   logic [2:0] bus_addr, store_addr;
   logic [DW-1:0] bus_wdata, bus_rdata_ff, rv;
   pldc_dyn_cfg_t store_wdata = STORE_RST;
   pldc_static_cfg_t scfg = '0;
   pldc_la_cfg_t la_cfg0 = '0;
   pldc_la_cfg_t la_cfg1 = '0;
   logic [LA_INPUTS-1:0] la_in0 = '0;
   logic [LA_INPUTS-1:0] la_in1 = '0;
   logic [LA_OUTS-1:0] la_out0, la_out1;
   logic [ROUTE_INS-1:0] route_in = '0;
   logic [ROUTE_OUTS-1:0] route_out_ff;
   pldc_chain_t chain_out;
   pldc_chain_t chain_seen;
   pldc_dyn_cfg_t word_cfg;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // a=8'h5a, d=8'h33, or mask 8'h81, shift-in 0
   pldc_row_t rows [12] = '{'{ALU_PASS, POST_NONE, 8'h5a}, '{ALU_INC, POST_NONE, 8'h5b},
      '{ALU_DEC, POST_NONE, 8'h59}, '{ALU_ADD, POST_NONE, 8'h8d}, '{ALU_SUB, POST_NONE, 8'h27},
      '{ALU_AND, POST_NONE, 8'h12}, '{ALU_OR, POST_NONE, 8'h7b}, '{ALU_XOR, POST_NONE, 8'h69},
      '{ALU_PASS, POST_SHL, 8'hb4}, '{ALU_PASS, POST_SHR, 8'h2d},
      '{ALU_PASS, POST_SWAP, 8'ha5}, '{ALU_PASS, POST_ORM, 8'hdb}};
   always #12.5 clk = ~clk;
   initial store_wr = 1'b0;
   initial store_addr = 3'h0;
   pldc_bus_host pldc_bus_host_inst (.clk(clk), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff));
   pldc_cell pldc_cell_inst (.clk(clk), .reset_n(reset_n), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
      .store_wr(store_wr), .store_addr(store_addr), .store_wdata(store_wdata),
      .static_cfg(scfg), .la_cfg0(la_cfg0), .la_cfg1(la_cfg1), .la_in0(la_in0),
      .la_in1(la_in1), .la_out0(la_out0), .la_out1(la_out1), .route_in(route_in),
      .route_out_ff(route_out_ff), .chain_in(4'h0), .chain_out(chain_out));
   task automatic complete_run();
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : check
   task automatic store(input logic [2:0] a, input pldc_dyn_cfg_t w);
      @(negedge clk);
      store_addr = a;
      store_wdata = w;
      store_wr = 1'b1;
      @(negedge clk);
      store_wr = 1'b0;
      store_wdata = ~w;
   endtask : store
   // word a runs for exactly one edge, word 0 (no destination) otherwise
   task automatic step(input logic [2:0] a);
      @(negedge clk);
      route_in[2:0] = a;
      // chain outputs have no flop, so look while word a is live
      #1 chain_seen = chain_out;
      @(negedge clk);
      route_in[2:0] = 3'h0;
   endtask : step
   function automatic pldc_dyn_cfg_t mk(input pldc_alu_op_t op, input pldc_post_t post);
      pldc_dyn_cfg_t w;
      w = STORE_RST;
      w.op = op;
      w.opa = SRC_ACC0;
      w.opb = SRC_DAT0;
      w.post = post;
      w.dst = 2'h1;
      return w;
   endfunction : mk
   task automatic do_reset();
      reset_n = 1'b0;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      for (int a = 0; a < 7; a++) begin
         pldc_bus_host_inst.rd(3'(a), rv);
         check("reset read", 8'h00, rv);
      end
      check("reset conditions", 8'h16, {2'b00, route_out_ff});
   endtask : do_reset
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      scfg.msb = MSB_TOP;
      scfg.out_mask = ALL_ONES;
      scfg.or_mask = 8'h81;
      scfg.cmp_mask = {ALL_ONES, ALL_ONES};
      scfg.fifo_out_dir = 2'b10;
      scfg.out_sel = {CND_CARRY, CND_FIFO1_EMPTY, CND_ONES1, CND_ZERO0, CND_FIFO0_EMPTY,
         CND_FIFO0_FULL};
      la_cfg0.use_true[0][1:0] = 2'b11;
      la_cfg0.or_sel[0] = 8'h01;
      la_cfg1.use_comp[0][0] = 1'b1;
      la_cfg1.or_sel[0] = 8'h01;
      la_cfg1.reg_out = 4'h1;
      do_reset();
      foreach (rows[i]) begin
         pldc_bus_host_inst.wr(OFS_ACC0, 8'h5a);
         pldc_bus_host_inst.wr(OFS_DAT0, 8'h33);
         store(3'h1, mk(rows[i].op, rows[i].post));
         step(3'h1);
         pldc_bus_host_inst.rd(OFS_ACC0, rv);
         check("alu result", rows[i].exp, rv);
      end
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         la_in0 = 12'(i);
         la_in1 = 12'(i);
         @(negedge clk);
         check("array and", {7'h0, i == 3}, {4'h0, la_out0});
         check("array flop", {7'h0, i[0] == 1'b0}, {4'h0, la_out1});
      end
      for (int i = 0; i < 5; i++) begin
         pldc_bus_host_inst.wr(OFS_FIFO0, 8'h10 + 8'(i));
      end
      pldc_bus_host_inst.rd(OFS_FIFO0, rv);
      check("fifo0 head", 8'h10, rv);
      check("fifo0 full", 8'h01, {6'h00, route_out_ff[1:0]});
      pldc_bus_host_inst.wr(OFS_FIFO1, 8'h77);
      pldc_bus_host_inst.rd(OFS_FIFO1, rv);
      check("fifo1 empty read", 8'h00, rv);
      check("fifo1 empty flag", 8'h01, {7'h00, route_out_ff[4]});
      pldc_bus_host_inst.wr(OFS_ACC1, ALL_ONES);
      repeat (2) @(negedge clk);
      check("ones and zero", 8'h02, {6'h00, route_out_ff[3:2]});
      // input fifo 0 (full, head 8'h10) feeds accumulator 0
      word_cfg = mk(ALU_PASS, POST_NONE);
      word_cfg.dst = 2'h0;
      word_cfg.acc_load = 1'b1;
      store(3'h2, word_cfg);
      step(3'h2);
      pldc_bus_host_inst.rd(OFS_ACC0, rv);
      check("fifo0 load", 8'h10, rv);
      pldc_bus_host_inst.rd(OFS_FIFO0, rv);
      check("fifo0 next", 8'h11, rv);
      // 8'hf0 + 8'h33 carries out; the sum goes into output fifo 1
      pldc_bus_host_inst.wr(OFS_ACC0, 8'hf0);
      word_cfg = mk(ALU_ADD, POST_NONE);
      word_cfg.dst = 2'h0;
      word_cfg.fifo_capture = 1'b1;
      word_cfg.fifo_from_alu = 1'b1;
      store(3'h3, word_cfg);
      step(3'h3);
      check("chain out", 8'h08, {4'h0, chain_seen});
      check("carry route", 8'h01, {7'h0, route_out_ff[5]});
      pldc_bus_host_inst.rd(OFS_FIFO1, rv);
      check("fifo1 capture", 8'h23, rv);
      // one crc step on 8'hf0 with polynomial 8'h07 and data in 0
      scfg.crc_en = 1'b1;
      scfg.poly = 8'h07;
      store(3'h4, mk(ALU_PASS, POST_NONE));
      step(3'h4);
      scfg.crc_en = 1'b0;
      pldc_bus_host_inst.rd(OFS_ACC0, rv);
      check("crc step", 8'he7, rv);
      do_reset();
      complete_run();
   end
endmodule : programmable_logic_datapath_cell_bench
`default_nettype wire
